// ### include/i2cmc_pkg.sv
// Register map, field positions and state types of the I2C master controller.
package i2cmc_pkg;
   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_GLOBAL_INTERRUPT_CONTROL = 8'h0b;
   localparam logic [7:0] IDX_PERIPHERAL_FLAGS_ONE = 8'h0c;
   localparam logic [7:0] IDX_PERIPHERAL_FLAGS_TWO = 8'h0d;
   localparam logic [7:0] IDX_SERIAL_BUFFER = 8'h13;
   localparam logic [7:0] IDX_SERIAL_CONTROL_ONE = 8'h14;
   localparam logic [7:0] IDX_PERIPHERAL_ENABLES_ONE = 8'h8c;
   localparam logic [7:0] IDX_PERIPHERAL_ENABLES_TWO = 8'h8d;
   localparam logic [7:0] IDX_SERIAL_CONTROL_TWO = 8'h91;
   localparam logic [7:0] IDX_SLAVE_ADDRESS_OR_BAUD_RELOAD = 8'h93;
   localparam logic [7:0] IDX_SERIAL_STATUS = 8'h94;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int GLOBAL_IRQ_ENABLE = 7;
   localparam int PERIPHERAL_IRQ_ENABLE = 6;
   localparam int SERIAL_IRQ_FLAG = 3;
   localparam int BUS_COLLISION_FLAG = 3;
   localparam logic [7:0] FLAGS_TWO_MASK = 8'h19;
   localparam int WRITE_COLLISION_FLAG = 7;
   localparam int RECEIVE_OVERFLOW_FLAG = 6;
   localparam int PORT_ENABLE = 5;
   localparam logic [3:0] MODE_MASTER = 4'h8;
   localparam int GENERAL_CALL_ENABLE = 7;
   localparam int ACK_STATUS = 6;
   localparam int ACK_DATA_VALUE = 5;
   localparam int ACK_SEQUENCE_ENABLE = 4;
   localparam int RECEIVE_ENABLE = 3;
   localparam int STOP_ENABLE = 2;
   localparam int REPEATED_START_ENABLE = 1;
   localparam int START_ENABLE = 0;
   localparam logic [7:0] CONTROL_TWO_CMD_MASK = 8'h1f;
   localparam int STOP_DETECTED = 4;
   localparam int START_DETECTED = 3;
   localparam int BUFFER_FULL = 0;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   // ------------------------------------------------------------------
   // State types
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE, ST_START_WAIT, ST_START_HOLD, ST_RS_LOW, ST_RS_RISE, ST_RS_HIGH,
      ST_RS_HOLD, ST_SH_LOW, ST_SH_RISE, ST_SH_HIGH, ST_SP_LOW, ST_SP_RISE,
      ST_SP_HIGH, ST_SP_DONE
   } i2cmc_state_e;
   typedef enum logic [1:0] {K_TX, K_RX, K_ACK} i2cmc_kind_e;
endpackage : i2cmc_pkg

// ### rtl/i2cmc_reset_sync.sv
// Two-stage release synchroniser for the asynchronous active-low reset.
`timescale 1ns/1ps
module i2cmc_reset_sync (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   output logic o_rst_n
);
   typedef struct packed {
      logic s1;
      logic s2;
   } i2cmc_rsync_s;
   i2cmc_rsync_s r;
   i2cmc_rsync_s n;
   always_comb begin
      n.s1 = 1'b1;
      n.s2 = r.s1;
   end
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign o_rst_n = r.s2;
endmodule : i2cmc_reset_sync

// ### rtl/i2cmc_rate_counter.sv
// Reloadable down counter that times one bit-rate period and then halts.
`timescale 1ns/1ps
module i2cmc_rate_counter #(
   parameter int W = 7
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [W-1:0] i_reload,
   output logic o_expired
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic run;
      logic exp;
   } i2cmc_rate_s;
   i2cmc_rate_s r;
   i2cmc_rate_s n;
   always_comb begin
      n = r;
      n.exp = 1'b0;
      if (i_load) begin
         n.cnt = i_reload;
         n.run = 1'b1;
      end else if (r.run) begin
         if (r.cnt == '0) begin
            n.run = 1'b0;
            n.exp = 1'b1;
         end else begin
            n.cnt = r.cnt - 1'b1;
         end
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign o_expired = r.exp;
endmodule : i2cmc_rate_counter

// ### rtl/i2cmc_top.sv
// I2C master controller with Avalon-MM register slave and open-drain bus pins.
// Functional notes
// - Reset or port disable aborts any transfer and releases both lines.
// - Start and stop detected bits clear on reset and while disabled.
// - Interrupt flag sets on start, stop, byte, ack sent, repeated start.
// - Stop seen on a busy bus raises the interrupt flag.
// - Sensed SDA low while the device releases it sets bus collision.
// - Collision checked in address, data, start, repeated start, ack.
// - Buffer write while busy is dropped and sets write collision.
// - Hardware makes every clock pulse and all start and stop conditions.
// - Repeated start keeps the bus; stop releases it.
// - Transmit sends eight bits then samples the slave acknowledge.
// - Receive shifts in eight bits; acknowledge sent on request.
// - Bit period reload comes from the low seven address bits.
// - Counter starts on buffer write, stops after ack with SCL held.
// - Start completion sets the flag after the hold period.
// - Slave acknowledge is stored in the ack status bit.
// - Flag sets at the end of the ninth clock of each transmitted byte, the eighth of each received byte.
// - Stop enable makes a stop; flag set once it completes.
// - Counter counts down to zero then halts until reloaded.
// - Lines low at start, or SCL low early, abort start with collision.
// - Start enable self-clears after the second timeout, SDA held low.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
module i2cmc_top
   import i2cmc_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   input wire logic [ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_scl,
   output logic o_scl,
   output logic o_scl_oe,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   output logic o_irq
);
   typedef struct packed {
      i2cmc_state_e st;
      i2cmc_kind_e kind;
      logic [3:0] cnt;
      logic [7:0] shf;
      logic [7:0] rxb;
      logic scl_oe;
      logic sda_oe;
      logic [7:0] gic;
      logic [7:0] pf1;
      logic [7:0] pf2;
      logic [7:0] pe1;
      logic [7:0] pe2;
      logic [7:0] c1;
      logic [7:0] c2;
      logic [7:0] adr;
      logic [1:0] stc;
      logic s_det;
      logic p_det;
      logic full;
      logic sda_q;
      logic scl_q;
      logic waitreq;
      logic [7:0] rdat;
      logic irq;
   } i2cmc_regs_s;

   i2cmc_regs_s r;
   i2cmc_regs_s n;
   logic rst_n;
   logic done;
   logic load;
   logic bcl;
   logic req;
   logic wr_go;
   logic rd_go;
   logic en_mst;
   logic [7:0] idx;
   logic [7:0] wd;

   // Level the device intends on SDA in the current bit; one means released.
   function automatic logic want_level(input i2cmc_kind_e k, input logic [3:0] c,
                                       input logic [7:0] s, input logic ackv);
      logic v;
      v = 1'b1;
      if (k == K_TX && c <= LAST_DATA_BIT) begin
         v = s[7];
      end else if (k == K_ACK) begin
         v = ackv;
      end
      return v;
   endfunction : want_level

   i2cmc_reset_sync u_rst (
      .i_sys_clk(i_sys_clk),
      .i_rstn(i_rstn),
      .o_rst_n(rst_n)
   );

   i2cmc_rate_counter #(.W(7)) u_rate (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(rst_n),
      .i_load(load),
      .i_reload(r.adr[6:0]),
      .o_expired(done)
   );

   assign req = i_avs_read || i_avs_write;
   assign idx = i_avs_address[9:2];
   assign wd = i_avs_writedata[7:0];
   assign wr_go = i_avs_write && !r.waitreq && i_avs_byteenable[0];
   assign rd_go = i_avs_read && !r.waitreq;
   assign en_mst = r.c1[PORT_ENABLE] && (r.c1[3:0] == MODE_MASTER);

   always_comb begin
      n = r;
      load = 1'b0;
      bcl = 1'b0;
      // ------------------------------------------------------------------
      // Register slave: one wait cycle, read data captured with the answer
      // ------------------------------------------------------------------
      n.waitreq = !(req && r.waitreq);
      if (req && r.waitreq) begin
         case (idx)
            IDX_GLOBAL_INTERRUPT_CONTROL: n.rdat = r.gic;
            IDX_PERIPHERAL_FLAGS_ONE: n.rdat = r.pf1;
            IDX_PERIPHERAL_FLAGS_TWO: n.rdat = r.pf2;
            IDX_SERIAL_BUFFER: n.rdat = r.rxb;
            IDX_SERIAL_CONTROL_ONE: n.rdat = r.c1;
            IDX_PERIPHERAL_ENABLES_ONE: n.rdat = r.pe1;
            IDX_PERIPHERAL_ENABLES_TWO: n.rdat = r.pe2;
            IDX_SERIAL_CONTROL_TWO: n.rdat = r.c2;
            IDX_SLAVE_ADDRESS_OR_BAUD_RELOAD: n.rdat = r.adr;
            IDX_SERIAL_STATUS: n.rdat = {r.stc, 1'b0, r.p_det, r.s_det, 2'b00, r.full};
            default: n.rdat = 8'h00;
         endcase
      end
      if (rd_go && idx == IDX_SERIAL_BUFFER && r.st == ST_IDLE) begin
         n.full = 1'b0;
      end
      if (wr_go) begin
         case (idx)
            IDX_GLOBAL_INTERRUPT_CONTROL: n.gic = wd;
            IDX_PERIPHERAL_FLAGS_ONE: n.pf1 = wd;
            IDX_PERIPHERAL_FLAGS_TWO: n.pf2 = wd & FLAGS_TWO_MASK;
            IDX_PERIPHERAL_ENABLES_ONE: n.pe1 = wd;
            IDX_PERIPHERAL_ENABLES_TWO: n.pe2 = wd & FLAGS_TWO_MASK;
            IDX_SERIAL_CONTROL_ONE: n.c1 = wd;
            IDX_SLAVE_ADDRESS_OR_BAUD_RELOAD: n.adr = wd;
            IDX_SERIAL_STATUS: n.stc = wd[7:6];
            IDX_SERIAL_BUFFER: begin
               if (en_mst && r.st == ST_IDLE) begin
                  n.shf = wd;
                  n.full = 1'b1;
                  n.kind = K_TX;
                  n.cnt = 4'h0;
                  n.scl_oe = 1'b1;
                  load = 1'b1;
                  n.st = ST_SH_LOW;
               end else begin
                  n.c1[WRITE_COLLISION_FLAG] = 1'b1;
               end
            end
            IDX_SERIAL_CONTROL_TWO: begin
               n.c2[GENERAL_CALL_ENABLE] = wd[7];
               n.c2[ACK_DATA_VALUE] = wd[5];
               // Commands are only taken from idle, and only the first by priority.
               if (en_mst && r.st == ST_IDLE) begin
                  if (wd[START_ENABLE]) begin
                     n.c2[START_ENABLE] = 1'b1;
                     if (!i_sda || !i_scl) begin
                        bcl = 1'b1;
                     end else begin
                        load = 1'b1;
                        n.st = ST_START_WAIT;
                     end
                  end else if (wd[REPEATED_START_ENABLE]) begin
                     n.c2[REPEATED_START_ENABLE] = 1'b1;
                     n.scl_oe = 1'b1;
                     n.sda_oe = 1'b0;
                     load = 1'b1;
                     n.st = ST_RS_LOW;
                  end else if (wd[STOP_ENABLE]) begin
                     n.c2[STOP_ENABLE] = 1'b1;
                     n.scl_oe = 1'b1;
                     n.sda_oe = 1'b1;
                     load = 1'b1;
                     n.st = ST_SP_LOW;
                  end else if (wd[RECEIVE_ENABLE]) begin
                     n.c2[RECEIVE_ENABLE] = 1'b1;
                     n.kind = K_RX;
                     n.cnt = 4'h0;
                     n.scl_oe = 1'b1;
                     load = 1'b1;
                     n.st = ST_SH_LOW;
                  end else if (wd[ACK_SEQUENCE_ENABLE]) begin
                     n.c2[ACK_SEQUENCE_ENABLE] = 1'b1;
                     n.kind = K_ACK;
                     n.cnt = ACK_BIT;
                     n.scl_oe = 1'b1;
                     load = 1'b1;
                     n.st = ST_SH_LOW;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      // ------------------------------------------------------------------
      // Bus sequencer; every wait below is one bit-rate period, except the rise states, which wait for SCL high
      // ------------------------------------------------------------------
      case (r.st)
         ST_START_WAIT: begin
            if (!i_scl || !i_sda) begin
               bcl = 1'b1;
            end else if (done) begin
               n.sda_oe = 1'b1;
               load = 1'b1;
               n.st = ST_START_HOLD;
            end
         end
         ST_START_HOLD: begin
            if (done) begin
               n.c2[START_ENABLE] = 1'b0;
               n.pf1[SERIAL_IRQ_FLAG] = 1'b1;
               n.st = ST_IDLE;
            end
         end
         ST_RS_LOW: begin
            if (done) begin
               if (!i_sda) begin
                  bcl = 1'b1;
               end else begin
                  n.scl_oe = 1'b0;
                  n.st = ST_RS_RISE;
               end
            end
         end
         ST_RS_RISE: begin
            if (i_scl) begin
               load = 1'b1;
               n.st = ST_RS_HIGH;
            end
         end
         ST_RS_HIGH: begin
            if (!i_sda || !i_scl) begin
               bcl = 1'b1;
            end else if (done) begin
               n.sda_oe = 1'b1;
               load = 1'b1;
               n.st = ST_RS_HOLD;
            end
         end
         ST_RS_HOLD: begin
            if (done) begin
               // The bus stays owned: SDA is left low with SCL high.
               n.c2[REPEATED_START_ENABLE] = 1'b0;
               n.pf1[SERIAL_IRQ_FLAG] = 1'b1;
               n.st = ST_IDLE;
            end
         end
         ST_SH_LOW: begin
            n.sda_oe = !want_level(r.kind, r.cnt, r.shf, r.c2[ACK_DATA_VALUE]);
            if (done) begin
               n.scl_oe = 1'b0;
               n.st = ST_SH_RISE;
            end
         end
         ST_SH_RISE: begin
            // A slave stretching SCL holds us here; the period starts on release.
            if (i_scl) begin
               load = 1'b1;
               n.st = ST_SH_HIGH;
            end
         end
         ST_SH_HIGH: begin
            if (done) begin
               if (want_level(r.kind, r.cnt, r.shf, r.c2[ACK_DATA_VALUE]) && !i_sda
                   && r.kind != K_RX && !(r.kind == K_TX && r.cnt == ACK_BIT)) begin
                  bcl = 1'b1;
               end else begin
                  n.scl_oe = 1'b1;
                  if (r.kind == K_TX) begin
                     n.shf = {r.shf[6:0], 1'b0};
                  end else if (r.kind == K_RX) begin
                     n.shf = {r.shf[6:0], i_sda};
                  end
                  if (r.kind == K_TX && r.cnt == LAST_DATA_BIT) begin
                     n.full = 1'b0;
                  end
                  if (r.kind == K_TX && r.cnt == ACK_BIT) begin
                     n.c2[ACK_STATUS] = i_sda;
                     n.pf1[SERIAL_IRQ_FLAG] = 1'b1;
                     n.st = ST_IDLE;
                  end else if (r.kind == K_RX && r.cnt == LAST_DATA_BIT) begin
                     n.rxb = {r.shf[6:0], i_sda};
                     // Built on the next value so a software clear in this cycle is kept.
                     n.c1[RECEIVE_OVERFLOW_FLAG] = n.c1[RECEIVE_OVERFLOW_FLAG] | r.full;
                     n.full = 1'b1;
                     n.c2[RECEIVE_ENABLE] = 1'b0;
                     n.pf1[SERIAL_IRQ_FLAG] = 1'b1;
                     n.st = ST_IDLE;
                  end else if (r.kind == K_ACK) begin
                     n.c2[ACK_SEQUENCE_ENABLE] = 1'b0;
                     n.sda_oe = 1'b0;
                     n.pf1[SERIAL_IRQ_FLAG] = 1'b1;
                     n.st = ST_IDLE;
                  end else begin
                     n.cnt = r.cnt + 4'h1;
                     load = 1'b1;
                     n.st = ST_SH_LOW;
                  end
               end
            end
         end
         ST_SP_LOW: begin
            if (done) begin
               n.scl_oe = 1'b0;
               n.st = ST_SP_RISE;
            end
         end
         ST_SP_RISE: begin
            if (i_scl) begin
               load = 1'b1;
               n.st = ST_SP_HIGH;
            end
         end
         ST_SP_HIGH: begin
            if (done) begin
               n.sda_oe = 1'b0;
               load = 1'b1;
               n.st = ST_SP_DONE;
            end
         end
         ST_SP_DONE: begin
            if (done) begin
               n.c2[STOP_ENABLE] = 1'b0;
               n.pf1[SERIAL_IRQ_FLAG] = 1'b1;
               n.st = ST_IDLE;
            end
         end
         default: begin
         end
      endcase
      if (bcl) begin
         n.pf2[BUS_COLLISION_FLAG] = 1'b1;
         n.c2 = n.c2 & ~CONTROL_TWO_CMD_MASK;
         n.scl_oe = 1'b0;
         n.sda_oe = 1'b0;
         n.full = 1'b0;
         n.st = ST_IDLE;
      end
      // ------------------------------------------------------------------
      // Bus monitor for start and stop seen on the wires
      // ------------------------------------------------------------------
      n.sda_q = i_sda;
      n.scl_q = i_scl;
      if (r.scl_q && i_scl && r.sda_q && !i_sda) begin
         n.s_det = 1'b1;
         n.p_det = 1'b0;
      end
      if (r.scl_q && i_scl && !r.sda_q && i_sda) begin
         n.p_det = 1'b1;
         n.s_det = 1'b0;
         if (r.s_det) begin
            n.pf1[SERIAL_IRQ_FLAG] = 1'b1;
         end
      end
      if (!r.c1[PORT_ENABLE]) begin
         n.s_det = 1'b0;
         n.p_det = 1'b0;
         n.st = ST_IDLE;
         n.scl_oe = 1'b0;
         n.sda_oe = 1'b0;
         n.c2 = n.c2 & ~CONTROL_TWO_CMD_MASK;
      end
      n.irq = r.gic[GLOBAL_IRQ_ENABLE] && r.gic[PERIPHERAL_IRQ_ENABLE]
              && ((r.pf1[SERIAL_IRQ_FLAG] && r.pe1[SERIAL_IRQ_FLAG])
              || (r.pf2[BUS_COLLISION_FLAG] && r.pe2[BUS_COLLISION_FLAG]));
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.waitreq <= 1'b1;
         r.sda_q <= 1'b1;
         r.scl_q <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign o_avs_readdata = {24'h00_0000, r.rdat};
   assign o_avs_waitrequest = r.waitreq;
   assign o_scl = 1'b0;
   assign o_sda = 1'b0;
   assign o_scl_oe = r.scl_oe;
   assign o_sda_oe = r.sda_oe;
   assign o_irq = r.irq;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!rst_n);

   a_disable_clears: assert property (!r.c1[PORT_ENABLE] |=> !r.s_det && !r.p_det)
      else $error("start or stop bit kept while disabled");
   a_disable_release: assert property (!r.c1[PORT_ENABLE] |=> !o_scl_oe && !o_sda_oe
      && r.st == ST_IDLE)
      else $error("bus not released while disabled");
   a_write_collision_flag_busy: assert property (wr_go && idx == IDX_SERIAL_BUFFER && r.st != ST_IDLE
      && !(r.st == ST_SH_HIGH && done)
      |=> r.c1[WRITE_COLLISION_FLAG] && $stable(r.shf))
      else $error("busy buffer write not refused");
   a_bit_collide: assert property (r.st == ST_SH_HIGH && done && r.kind == K_TX
      && r.cnt <= LAST_DATA_BIT && r.shf[7] && !i_sda && r.c1[PORT_ENABLE]
      |=> r.pf2[BUS_COLLISION_FLAG] && r.st == ST_IDLE && !o_sda_oe)
      else $error("lost arbitration not flagged");
   a_ninth_irq: assert property (r.st == ST_SH_HIGH && done && r.kind == K_TX
      && r.cnt == ACK_BIT && r.c1[PORT_ENABLE]
      |=> r.pf1[SERIAL_IRQ_FLAG] && o_scl_oe && r.c2[ACK_STATUS] == $past(i_sda))
      else $error("ninth clock did not flag or store ack");
   a_start_done: assert property (r.st == ST_START_HOLD && done && r.c1[PORT_ENABLE]
      |=> !r.c2[START_ENABLE] && o_sda_oe && r.pf1[SERIAL_IRQ_FLAG])
      else $error("start did not complete correctly");
   a_stop_irq: assert property (r.st == ST_SP_DONE && done && r.c1[PORT_ENABLE]
      |=> r.pf1[SERIAL_IRQ_FLAG] && r.st == ST_IDLE && !o_sda_oe)
      else $error("stop completion not flagged");
   a_bus_stop: assert property ($rose(r.p_det) && $past(r.s_det)
      |-> r.pf1[SERIAL_IRQ_FLAG])
      else $error("stop on busy bus not flagged");
   a_wait_answer: assert property (req && o_avs_waitrequest
      |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer not one cycle");
   a_timer_wait: assert property (r.st == ST_SP_LOW && $past(r.st) != ST_SP_LOW
      |-> ##[1:130] (done || r.st != ST_SP_LOW))
      else $error("bit period did not expire");
endmodule : i2cmc_top

// ### bench/i2cmc_slave_model.sv
// Behavioural I2C slave that collects written bytes and answers with an acknowledge.
`timescale 1ns/1ps
module i2cmc_slave_model (
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_ack_en,
   output logic o_sda_oe,
   output logic [7:0] o_last_byte
);
   logic [3:0] bit_cnt;
   logic [7:0] shift_r;
   initial begin
      bit_cnt = 4'h0;
      shift_r = 8'h00;
      o_sda_oe = 1'b0;
      o_last_byte = 8'h00;
   end
   // A start or stop seen on the wires restarts the bit count.
   always @(i_sda) begin
      if (i_scl === 1'b1) begin
         bit_cnt = 4'h0;
      end
   end
   always @(posedge i_scl) begin
      if (bit_cnt < 4'h8) begin
         shift_r = {shift_r[6:0], i_sda};
      end
      bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == 4'h8) begin
         o_last_byte = shift_r;
      end
   end
   // The line is only pulled low, never driven high, as on a real open-drain bus.
   always @(negedge i_scl) begin
      if (bit_cnt == 4'h8) begin
         o_sda_oe = i_ack_en;
      end else begin
         o_sda_oe = 1'b0;
         if (bit_cnt == 4'h9) begin
            bit_cnt = 4'h0;
         end
      end
   end
endmodule : i2cmc_slave_model

// ### bench/test_i2cmc_top.sv
// Register-level testbench of the I2C master controller.
`timescale 1ns/1ps
module test_i2cmc_top;
   import i2cmc_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [9:0] addr = 10'h000;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic waitreq, scl_oe, sda_oe, slv_oe, irq, ack_en, scl_o, sda_o;
   logic [7:0] slv_byte, v;
   wire scl_w = ~scl_oe;
   wire sda_w = ~(sda_oe | slv_oe);
   int err_total = 0;
   int checked = 0;
   i2cmc_top dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd_en),
      .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_scl(scl_w), .o_scl(scl_o),
      .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(sda_o), .o_sda_oe(sda_oe), .o_irq(irq));
   i2cmc_slave_model slv_u (.i_scl(scl_w), .i_sda(sda_w), .i_ack_en(ack_en), .o_sda_oe(slv_oe),
      .o_last_byte(slv_byte));
   initial begin
      forever #50 clk = ~clk;
   end
   // ------------------------------------------------------------------
   // Bus access and checking tasks
   // ------------------------------------------------------------------
   task automatic acc(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
      int n;
      @(posedge clk);
      addr <= {idx, 2'b00};
      wr_en <= wr;
      rd_en <= !wr;
      wdata <= {24'h00_0000, wd};
      // Answer and read data are taken at the rising edge that sees waitrequest low.
      for (n = 0; n < 50; n++) begin
         @(posedge clk);
         if (waitreq === 1'b0) break;
      end
      if (n == 50) err_total++;
      rd = rdata[7:0];
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask : acc
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [7:0] d;
      acc(1'b1, idx, wd, d);
   endtask : wr
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] msk,
                        input logic [7:0] exp);
      logic [7:0] d;
      acc(1'b0, idx, 8'h00, d);
      chk(what, exp, d & msk);
   endtask : rdchk
   // Polls the interrupt flag, checks the request line, then clears the flag in software.
   task automatic wait_flag();
      logic [7:0] d;
      for (int n = 0; n < 400; n++) begin
         acc(1'b0, IDX_PERIPHERAL_FLAGS_ONE, 8'h00, d);
         if (d[SERIAL_IRQ_FLAG] === 1'b1) break;
      end
      chk("flag", 8'h08, d & 8'h08);
      chk("irq", 8'h01, {7'h00, irq});
      wr(IDX_PERIPHERAL_FLAGS_ONE, 8'h00);
   endtask : wait_flag
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   // ------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------
   initial begin
      ack_en = 1'b1;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rdchk("status", IDX_SERIAL_STATUS, 8'hff, 8'h00);
      rdchk("control two", IDX_SERIAL_CONTROL_TWO, 8'hff, 8'h00);
      rdchk("unmapped", 8'h20, 8'hff, 8'h00);
      wr(IDX_SLAVE_ADDRESS_OR_BAUD_RELOAD, 8'h81);
      rdchk("reload", IDX_SLAVE_ADDRESS_OR_BAUD_RELOAD, 8'hff, 8'h81);
      wr(IDX_SERIAL_CONTROL_ONE, 8'h28);
      wr(IDX_GLOBAL_INTERRUPT_CONTROL, 8'hc0);
      wr(IDX_PERIPHERAL_ENABLES_ONE, 8'h08);
      wr(IDX_SERIAL_CONTROL_TWO, 8'h01);
      wr(IDX_SERIAL_BUFFER, 8'h55);
      rdchk("write collision", IDX_SERIAL_CONTROL_ONE, 8'hff, 8'ha8);
      wait_flag();
      rdchk("start self clear", IDX_SERIAL_CONTROL_TWO, 8'h1f, 8'h00);
      rdchk("start seen", IDX_SERIAL_STATUS, 8'h18, 8'h08);
      wr(IDX_SERIAL_CONTROL_ONE, 8'h28);
      rdchk("write_collision_flag cleared", IDX_SERIAL_CONTROL_ONE, 8'hff, 8'h28);
      wr(IDX_SERIAL_BUFFER, 8'ha4);
      wait_flag();
      chk("address byte", 8'ha4, slv_byte);
      rdchk("ack seen", IDX_SERIAL_CONTROL_TWO, 8'h40, 8'h00);
      ack_en <= 1'b0;
      wr(IDX_SERIAL_BUFFER, 8'h3c);
      wait_flag();
      chk("data byte", 8'h3c, slv_byte);
      rdchk("nack seen", IDX_SERIAL_CONTROL_TWO, 8'h40, 8'h40);
      wr(IDX_SERIAL_CONTROL_TWO, 8'h02);
      wait_flag();
      rdchk("rs self clear", IDX_SERIAL_CONTROL_TWO, 8'h1f, 8'h00);
      wr(IDX_SERIAL_CONTROL_TWO, 8'h08);
      wait_flag();
      rdchk("rx full", IDX_SERIAL_STATUS, 8'h01, 8'h01);
      rdchk("rx byte", IDX_SERIAL_BUFFER, 8'hff, 8'hff);
      wr(IDX_SERIAL_CONTROL_TWO, 8'h30);
      wait_flag();
      rdchk("ack self clear", IDX_SERIAL_CONTROL_TWO, 8'h3f, 8'h20);
      wr(IDX_SERIAL_CONTROL_TWO, 8'h04);
      wait_flag();
      rdchk("stop seen", IDX_SERIAL_STATUS, 8'h18, 8'h10);
      chk("lines released", 8'h03, {6'h00, scl_w, sda_w});
      chk("pin values", 8'h00, {6'h00, scl_o, sda_o});
      wr(IDX_SERIAL_CONTROL_ONE, 8'h08);
      rdchk("disabled", IDX_SERIAL_STATUS, 8'h18, 8'h00);
      test_done();
   end
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      test_done();
   end
endmodule : test_i2cmc_top
